// ---- mppe_core.sv ----
`timescale 1ns/1ps
module mppe_core
  import mppe_pkg::*;
(
  input wire logic SYS_CLK_I,          // Core clock
  input wire logic RST_I,              // Synchronous reset, high
  input wire logic HSEL_I,             // AHB slave select
  input wire logic [31:0] HADDR_I,     // AHB address
  input wire logic [1:0] HTRANS_I,     // AHB transfer type
  input wire logic HWRITE_I,           // AHB write
  input wire logic [2:0] HSIZE_I,      // AHB size, word only
  input wire logic [31:0] HWDATA_I,    // AHB write data
  input wire logic HREADY_I,           // AHB bus ready
  output logic [31:0] HRDATA_O,        // AHB read data
  output logic HREADYOUT_O,            // AHB slave ready
  output logic HRESP_O,                // AHB response, always OKAY
  output logic BUSY_O                  // Instruction executing
);
  logic [15:0] w_ff [16];
  logic [39:0] first_accumulator_ff, second_accumulator_ff;
  logic [9:0] rdpg_ff;
  logic [8:0] wrpg_ff;
  logic [7:0] tbpg_ff;
  logic [15:0] sr_ff, ea_ff, hold_ff;
  logic [23:0] ir_ff;
  logic ill_ff, busy_ff, ph_ff, ph_wr_ff, ph_map_ff, hready_ff, hresp_ff;
  logic [11:0] ph_addr_ff;
  logic [31:0] hrdata_ff, rd_mux;
  mppe_state_e st_ff, nxt_st;

  // Bus decode
  wire take = HSEL_I & HTRANS_I[1] & HREADY_I;
  // Data phase waits while an instruction runs
  wire act = ph_ff & (st_ff == ST_IDLE);
  wire bus_wr = act & ph_wr_ff & ph_map_ff;
  wire hit_w = ph_map_ff & (ph_addr_ff[11:6] == A_WREG_PAGE);
  wire hit_m = ph_map_ff & ph_addr_ff[10];
  wire [3:0] bus_widx = ph_addr_ff[5:2];
  wire reg_wr = bus_wr & ~hit_w & ~hit_m;
  wire launch = reg_wr & (ph_addr_ff == A_INSTR);
  wire ex1 = (st_ff == ST_EXEC1);
  wire ex2 = (st_ff == ST_EXEC2);

  // Instruction fields
  wire [1:0] pp = ir_ff[11:10];
  wire [2:0] md_mode = ir_ff[6:4];
  wire [3:0] md_s = ir_ff[3:0];
  wire [3:0] md_s1 = md_s + 4'h1;
  wire [3:0] md_d = {ir_ff[10:8], 1'b0};
  wire [3:0] md_d1 = {ir_ff[10:8], 1'b1};
  wire is_movd = (ir_ff[23:12] == OP_MOVD) & ~ir_ff[11] & ~ir_ff[7];
  wire go_movd = is_movd & (md_mode <= AM_PREINC);
  wire is_pgl = (ir_ff[23:12] == OP_PG_LIT) & (pp != PG_BAD);
  wire is_pgr = (ir_ff[23:12] == OP_PG_REG) & (ir_ff[9:4] == 6'h00) & (pp != PG_BAD);
  wire is_psa = (ir_ff[23:16] == OP_PSA) & ~ir_ff[14] & (ir_ff[1:0] != AWB_BAD);
  wire legal = go_movd | is_pgl | is_pgr | is_psa;

  wire [15:0] md_ptr = w_ff[md_s];
  wire md_dec = (md_mode == AM_POSTDEC) | (md_mode == AM_PREDEC);
  wire md_inc = (md_mode == AM_POSTINC) | (md_mode == AM_PREINC);
  wire md_pre = (md_mode == AM_PREDEC) | (md_mode == AM_PREINC);
  wire [15:0] md_new = md_dec ? md_ptr - DWORD_STEP : (md_inc ? md_ptr + DWORD_STEP : md_ptr);
  wire [15:0] md_ea = md_pre ? md_new : md_ptr;
  wire md_direct = (md_mode == AM_DIR);

  wire [3:0] xi = ir_ff[9:6];
  wire [3:0] xr = xi[3] ? W_X1 : W_X0;
  wire [3:0] xd = {W_XD_HI, ir_ff[13:12]};
  wire x_en = (xi != PF_NONE);
  wire [15:0] x_new = w_ff[xr] + mppe_pf_step(xi[2:0]);
  wire [15:0] x_ea = (xi == PF_OFFSET) ? w_ff[xr] + w_ff[W_OFF] : w_ff[xr];
  wire [3:0] yi = ir_ff[5:2];
  wire [3:0] yr = yi[3] ? W_Y1 : W_Y0;
  wire [3:0] yd = {W_XD_HI, ir_ff[11:10]};
  wire y_en = (yi != PF_NONE);
  wire [15:0] y_new = w_ff[yr] + mppe_pf_step(yi[2:0]);
  wire [15:0] y_ea = (yi == PF_OFFSET) ? w_ff[yr] + w_ff[W_OFF] : w_ff[yr];
  wire [1:0] aa = ir_ff[1:0];
  // write-back uses the accumulator not named
  wire [39:0] acc_other = ir_ff[15] ? first_accumulator_ff : second_accumulator_ff;
  wire awb_mem = ex1 & is_psa & (aa == AWB_MEM);

  wire [15:0] x_rd, y_rd, b_rd, rnd;
  wire [15:0] x_addr = ex2 ? ea_ff + WORD_STEP : (is_psa ? x_ea : md_ea);
  wire dm_we = (bus_wr & hit_m) | awb_mem;
  wire [7:0] dm_widx = awb_mem ? mppe_word_idx(w_ff[W_AWB]) : ph_addr_ff[9:2];
  wire [15:0] dm_wdata = awb_mem ? rnd : HWDATA_I[15:0];

  mppe_dmem u_dmem (
    .clk_i(SYS_CLK_I),
    .x_idx_i(mppe_word_idx(x_addr)),
    .x_data_o(x_rd),
    .y_idx_i(mppe_word_idx(y_ea)),
    .y_data_o(y_rd),
    .b_idx_i(ph_addr_ff[9:2]),
    .b_data_o(b_rd),
    .we_i(dm_we),
    .w_idx_i(dm_widx),
    .w_data_i(dm_wdata)
  );

  mppe_round u_round (
    .acc_i(acc_other),
    .rnd_o(rnd)
  );

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: nxt_st = launch ? ST_EXEC1 : ST_IDLE;
      // double move takes a second cycle
      ST_EXEC1: nxt_st = go_movd ? ST_EXEC2 : ST_IDLE;
      ST_EXEC2: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (hit_w)
      rd_mux = {16'h0000, w_ff[bus_widx]};
    else if (hit_m)
      rd_mux = {16'h0000, b_rd};
    else if (ph_map_ff)
    begin
      case (ph_addr_ff)
        A_INSTR: rd_mux = {8'h00, ir_ff};
        A_STAT:
        begin
          rd_mux[STAT_BUSY_BIT] = busy_ff;
          rd_mux[STAT_ILL_BIT] = ill_ff;
        end
        A_SR: rd_mux = {16'h0000, sr_ff};
        A_RDPG: rd_mux = {22'h000000, rdpg_ff};
        A_WRPG: rd_mux = {23'h000000, wrpg_ff};
        A_TBPG: rd_mux = {24'h000000, tbpg_ff};
        A_FIRST_ACCUMULATOR_L: rd_mux = first_accumulator_ff[31:0];
        A_FIRST_ACCUMULATOR_H: rd_mux = {24'h000000, first_accumulator_ff[39:32]};
        A_SECOND_ACCUMULATOR_L: rd_mux = second_accumulator_ff[31:0];
        A_SECOND_ACCUMULATOR_H: rd_mux = {24'h000000, second_accumulator_ff[39:32]};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // Bus slave: one wait state, more while an instruction runs, then the answer
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      ph_ff <= 1'b0;
      ph_wr_ff <= 1'b0;
      ph_map_ff <= 1'b0;
      ph_addr_ff <= 12'h000;
      hready_ff <= 1'b1;
      hrdata_ff <= 32'h00000000;
      hresp_ff <= 1'b0;
    end
    else
    begin
      hresp_ff <= 1'b0;
      if (take)
      begin
        ph_ff <= 1'b1;
        ph_wr_ff <= HWRITE_I;
        ph_map_ff <= (HADDR_I[31:12] == 20'h00000);
        ph_addr_ff <= HADDR_I[11:0];
        hready_ff <= 1'b0;
      end
      else if (act)
      begin
        ph_ff <= 1'b0;
        hready_ff <= 1'b1;
        hrdata_ff <= ph_wr_ff ? 32'h00000000 : rd_mux;
      end
    end
  end

  // Sequencer and control state
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      st_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      ir_ff <= 24'h000000;
      ill_ff <= 1'b0;
      ea_ff <= 16'h0000;
      hold_ff <= 16'h0000;
    end
    else
    begin
      st_ff <= nxt_st;
      busy_ff <= (nxt_st != ST_IDLE);
      if (launch)
        ir_ff <= HWDATA_I[23:0];
      // Illegal instruction set wins over software clear
      if (ex1 & ~legal)
        ill_ff <= 1'b1;
      else if (reg_wr & (ph_addr_ff == A_STAT) & HWDATA_I[STAT_ILL_BIT])
        ill_ff <= 1'b0;
      if (ex1)
      begin
        ea_ff <= md_ea;
        hold_ff <= w_ff[md_s1];
      end
    end
  end

  // status untouched; exec never writes sr_ff
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      sr_ff <= SR_RST;
      rdpg_ff <= PAGE_RST;
      wrpg_ff <= PAGE_RST[8:0];
      tbpg_ff <= PAGE_RST[7:0];
      first_accumulator_ff <= 40'h0000000000;
      second_accumulator_ff <= 40'h0000000000;
    end
    else
    begin
      if (reg_wr)
      begin
        case (ph_addr_ff)
          A_SR: sr_ff <= HWDATA_I[15:0];
          A_RDPG: rdpg_ff <= HWDATA_I[9:0];
          A_WRPG: wrpg_ff <= HWDATA_I[8:0];
          A_TBPG: tbpg_ff <= HWDATA_I[7:0];
          A_FIRST_ACCUMULATOR_L: first_accumulator_ff[31:0] <= HWDATA_I;
          A_FIRST_ACCUMULATOR_H: first_accumulator_ff[39:32] <= HWDATA_I[7:0];
          A_SECOND_ACCUMULATOR_L: second_accumulator_ff[31:0] <= HWDATA_I;
          A_SECOND_ACCUMULATOR_H: second_accumulator_ff[39:32] <= HWDATA_I[7:0];
          default: sr_ff <= sr_ff;
        endcase
      end
      if (ex1 & is_pgl)
      begin
        if (pp == PG_RD)
          rdpg_ff <= ir_ff[9:0];
        else if (pp == PG_WR)
          wrpg_ff <= ir_ff[8:0];
        else
          tbpg_ff <= ir_ff[7:0];
      end
      if (ex1 & is_pgr)
      begin
        if (pp == PG_RD)
          rdpg_ff <= w_ff[md_s][9:0];
        else if (pp == PG_WR)
          wrpg_ff <= w_ff[md_s][8:0];
        else
          tbpg_ff <= w_ff[md_s][7:0];
      end
    end
  end

  // Working registers; destination writes come last and win
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      for (int i = 0; i < 16; i++)
        w_ff[i] <= W_RST;
    end
    else
    begin
      if (bus_wr & hit_w)
        w_ff[bus_widx] <= HWDATA_I[15:0];
      if (ex1 & go_movd)
      begin
        w_ff[md_s] <= md_new;
        w_ff[md_d] <= md_direct ? w_ff[md_s] : x_rd;
      end
      if (ex2)
        w_ff[md_d1] <= md_direct ? hold_ff : x_rd;
      // X and Y prefetch with pointer step
      if (ex1 & is_psa)
      begin
        if (x_en)
        begin
          w_ff[xr] <= x_new;
          w_ff[xd] <= x_rd;
        end
        if (y_en)
        begin
          w_ff[yr] <= y_new;
          w_ff[yd] <= y_rd;
        end
        if (aa == AWB_REG)
          w_ff[W_AWB] <= rnd;
        else if (aa == AWB_MEM)
          w_ff[W_AWB] <= w_ff[W_AWB] + WORD_STEP;
      end
    end
  end

  assign HRDATA_O = hrdata_ff;
  assign HREADYOUT_O = hready_ff;
  assign HRESP_O = hresp_ff;
  assign BUSY_O = busy_ff;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  movd_two_cycle_a:
    assert property (ex1 && go_movd |=> ex2 ##1 st_ff == ST_IDLE)
    else $error("double move did not take two cycles");
  movd_pair_a:
    assert property (ex1 && go_movd && md_direct |=> ##1
      (w_ff[md_d] == $past(w_ff[md_s], 2)) && (w_ff[md_d1] == $past(w_ff[md_s1], 2)))
    else $error("direct double move copied wrong pair");
  movd_step_a:
    assert property (ex1 && go_movd && md_mode == AM_POSTINC && md_s != md_d
      && md_s != md_d1 |=> w_ff[md_s] == $past(w_ff[md_s]) + DWORD_STEP)
    else $error("double move pointer step not four");
  page_lit_a:
    assert property (ex1 && is_pgl && pp == PG_WR |=> wrpg_ff == $past(ir_ff[8:0]))
    else $error("literal write page load wrong");
  page_reg_a:
    assert property (ex1 && is_pgr && pp == PG_TBL |=> tbpg_ff == $past(w_ff[md_s][7:0]))
    else $error("register table page load wrong");
  page_one_a:
    assert property (ex1 && (is_pgl || is_pgr) |=> st_ff == ST_IDLE && $stable(sr_ff))
    else $error("page load not single cycle");
  flags_keep_a:
    assert property (st_ff != ST_IDLE |=> $stable(sr_ff))
    else $error("status changed by execution");
  pf_x_step_a:
    assert property (ex1 && is_psa && x_en && xi != PF_OFFSET
      |=> w_ff[xr] == $past(w_ff[xr]) + mppe_pf_step(xi[2:0]) && st_ff == ST_IDLE)
    else $error("X pointer step wrong");
  pf_y_dest_a:
    assert property (ex1 && is_psa && y_en && yd != yr |=> w_ff[yd] == $past(y_rd))
    else $error("Y prefetch destination wrong");
  awb_post_a:
    assert property (ex1 && is_psa && aa == AWB_MEM
      |=> w_ff[W_AWB] == $past(w_ff[W_AWB]) + WORD_STEP)
    else $error("write-back pointer not advanced by two");
endmodule : mppe_core

// ---- mppe_dmem.sv ----
`timescale 1ns/1ps
module mppe_dmem
  import mppe_pkg::*;
(
  input wire logic clk_i,           // Core clock
  input wire logic [7:0] x_idx_i,   // X read word index
  output logic [15:0] x_data_o,     // X read data
  input wire logic [7:0] y_idx_i,   // Y read word index
  output logic [15:0] y_data_o,     // Y read data
  input wire logic [7:0] b_idx_i,   // Bus read word index
  output logic [15:0] b_data_o,     // Bus read data
  input wire logic we_i,            // Write strobe
  input wire logic [7:0] w_idx_i,   // Write word index
  input wire logic [15:0] w_data_i  // Write data
);
  logic [15:0] mem [DMEM_DEPTH];

  // Reads are asynchronous so a prefetch completes in its own cycle
  assign x_data_o = mem[x_idx_i];
  assign y_data_o = mem[y_idx_i];
  assign b_data_o = mem[b_idx_i];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[w_idx_i] <= w_data_i;
    end
  end
endmodule : mppe_dmem

// ---- mppe_mem_model.sv ----
`timescale 1ns/1ps
module mppe_mem_model;
  // Shadow of the data memory, filled alongside every bus write to it
  logic [15:0] mem [0:255];

  // word addressing
  // Byte bit 0 dropped, so the high word of a pair sits at EA+2
  function automatic logic [15:0] rd(input logic [15:0] a);
    return mem[a[8:1]];
  endfunction : rd
endmodule : mppe_mem_model

// ---- mppe_pkg.sv ----
package mppe_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC1, ST_EXEC2} mppe_state_e;

  localparam logic [11:0] OP_MOVD = 12'hBE0;
  localparam logic [11:0] OP_PG_LIT = 12'hFEC;
  localparam logic [11:0] OP_PG_REG = 12'hFED;
  localparam logic [7:0] OP_PSA = 8'hC7;

  localparam logic [1:0] PG_RD = 2'h0;
  localparam logic [1:0] PG_WR = 2'h1;
  localparam logic [1:0] PG_TBL = 2'h2;
  localparam logic [1:0] PG_BAD = 2'h3;

  localparam logic [2:0] AM_DIR = 3'h0;
  localparam logic [2:0] AM_POSTDEC = 3'h2;
  localparam logic [2:0] AM_POSTINC = 3'h3;
  localparam logic [2:0] AM_PREDEC = 3'h4;
  localparam logic [2:0] AM_PREINC = 3'h5;

  localparam logic [15:0] DWORD_STEP = 16'h0004;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  localparam logic [3:0] PF_NONE = 4'h4;
  localparam logic [3:0] PF_OFFSET = 4'hC;
  localparam logic [3:0] W_X0 = 4'h8;
  localparam logic [3:0] W_X1 = 4'h9;
  localparam logic [3:0] W_Y0 = 4'hA;
  localparam logic [3:0] W_Y1 = 4'hB;
  localparam logic [3:0] W_OFF = 4'hC;
  localparam logic [3:0] W_AWB = 4'hD;
  localparam logic [1:0] W_XD_HI = 2'h1;

  localparam logic [1:0] AWB_REG = 2'h0;
  localparam logic [1:0] AWB_MEM = 2'h1;
  localparam logic [1:0] AWB_BAD = 2'h3;
  localparam logic [39:0] RND_BIAS = 40'h0000008000;

  localparam logic [11:0] A_INSTR = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_SR = 12'h008;
  localparam logic [11:0] A_RDPG = 12'h00C;
  localparam logic [11:0] A_WRPG = 12'h010;
  localparam logic [11:0] A_TBPG = 12'h014;
  localparam logic [11:0] A_FIRST_ACCUMULATOR_L = 12'h018;
  localparam logic [11:0] A_FIRST_ACCUMULATOR_H = 12'h01C;
  localparam logic [11:0] A_SECOND_ACCUMULATOR_L = 12'h020;
  localparam logic [11:0] A_SECOND_ACCUMULATOR_H = 12'h024;
  localparam logic [5:0] A_WREG_PAGE = 6'h01;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ILL_BIT = 1;

  localparam int DMEM_DEPTH = 256;
  localparam logic [15:0] W_RST = 16'h0000;
  localparam logic [15:0] SR_RST = 16'h0000;
  localparam logic [9:0] PAGE_RST = 10'h000;

  function automatic logic [15:0] mppe_pf_step(input logic [2:0] code);
    case (code)
      3'h1: return 16'h0002;
      3'h2: return 16'h0004;
      3'h3: return 16'h0006;
      3'h5: return 16'hFFFA;
      3'h6: return 16'hFFFC;
      3'h7: return 16'hFFFE;
      default: return 16'h0000;
    endcase
  endfunction : mppe_pf_step

  // Data memory holds words; byte bit 0 is dropped
  function automatic logic [7:0] mppe_word_idx(input logic [15:0] byte_addr);
    return byte_addr[8:1];
  endfunction : mppe_word_idx
endpackage : mppe_pkg

// ---- mppe_round.sv ----
`timescale 1ns/1ps
module mppe_round
  import mppe_pkg::*;
(
  input wire logic [39:0] acc_i,  // Accumulator value
  output logic [15:0] rnd_o       // Rounded high word
);
  logic [39:0] sum;

  // Conventional rounding only; no saturation of the result
  assign sum = acc_i + RND_BIAS;
  assign rnd_o = sum[31:16];
endmodule : mppe_round

// ---- tb_move_page_prefetch_exec.sv ----
`timescale 1ns/1ps
module tb_move_page_prefetch_exec;
  import mppe_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic busy;
  int fail_count = 0;
  int check_count = 0;

  always #2.5 clk = ~clk;

  mppe_core DUT (.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .BUSY_O(busy));
  mppe_mem_model model ();

  task end_sim;
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Values seen right after an edge are those sampled at it
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task rdck(input logic [31:0] a, input logic [15:0] e, input string n);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(n, {16'h0, e}, q);
  endtask : rdck

  function automatic logic [31:0] wa(input int n);
    return 32'h40 + 32'(4 * n);
  endfunction : wa

  function automatic logic [31:0] mba(input logic [15:0] a);
    return 32'h400 + {22'h0, a[8:1], 2'b00};
  endfunction : mba

  task mem_put(input logic [15:0] a, input logic [15:0] d);
    model.mem[a[8:1]] = d;
    wr(mba(a), {16'h0, d});
  endtask : mem_put

  // Launch and count the cycles the core reports busy
  task exec(input logic [23:0] ins, input int cyc);
    int n;
    n = 0;
    wr({20'h0, A_INSTR}, {8'h0, ins});
    while (busy === 1'b1 && n < 8)
    begin
      n++;
      @(posedge clk);
    end
    chk("busy cycles", 32'(cyc), 32'(n));
  endtask : exec

  task t_reset;
    rdck({20'h0, A_SR}, 16'h0, "sr reset");
    rdck({20'h0, A_RDPG}, 16'h0, "rdpg reset");
    rdck(wa(4), 16'h0, "w4 reset");
    rdck(32'h0000_1008, 16'h0, "unmapped");
    wr({20'h0, A_SR}, 32'h00A5);
    wr(32'h0000_1008, 32'hFFFF);
    rdck({20'h0, A_SR}, 16'h00A5, "unmapped write");
  endtask : t_reset

  task t_movd_dir;
    wr(wa(2), 32'h12FB);
    wr(wa(3), 32'h9877);
    wr(wa(6), 32'h9833);
    wr(wa(7), 32'hFCC6);
    exec({12'hBE0, 4'h3, 4'h0, 4'h2}, 2);
    rdck(wa(6), 16'h12FB, "w6");
    rdck(wa(7), 16'h9877, "w7");
    rdck(wa(2), 16'h12FB, "w2");
  endtask : t_movd_dir

  task t_movd_ind;
    logic [15:0] ea;
    logic [15:0] np;
    for (int i = 0; i < 10; i++)
      mem_put(16'(16'h08F8 + 2 * i), 16'(16'hA000 + i));
    for (int p = 1; p <= 5; p++)
    begin
      ea = (p == 4) ? 16'h08FC : (p == 5) ? 16'h0904 : 16'h0900;
      np = (p == 2 || p == 4) ? 16'h08FC : (p == 1) ? 16'h0900 : 16'h0904;
      wr(wa(7), 32'h0900);
      exec({12'hBE0, 4'h2, 1'b0, 3'(p), 4'h7}, 2);
      rdck(wa(4), model.rd(ea), "low word");
      rdck(wa(5), model.rd(16'(ea + 2)), "high word");
      rdck(wa(7), np, "pointer");
    end
  endtask : t_movd_ind

  task t_pages;
    wr(wa(5), 32'hABCD);
    for (int pp = 0; pp < 3; pp++)
    begin
      exec({12'hFEC, 2'(pp), 10'h3FF}, 1);
      rdck({20'h0, A_RDPG} + 32'(4 * pp), 16'(10'h3FF >> pp), "lit page");
      exec({12'hFED, 2'(pp), 6'h00, 4'h5}, 1);
      rdck({20'h0, A_RDPG} + 32'(4 * pp), 16'hABCD & 16'(10'h3FF >> pp), "reg page");
    end
    wr({20'h0, A_STAT}, 32'h2);
    exec({12'hFEC, 2'h3, 10'h155}, 1);
    rdck({20'h0, A_STAT}, 16'h0002, "illegal page");
    rdck({20'h0, A_RDPG}, 16'h03CD, "rdpg kept");
    wr({20'h0, A_STAT}, 32'h2);
    rdck({20'h0, A_STAT}, 16'h0, "status clear");
  endtask : t_pages

  task t_psa;
    logic [15:0] st;
    for (int i = 0; i < 64; i++)
      mem_put(16'(16'h00F0 + 2 * i), 16'(16'hC000 + i));
    for (int k = 0; k < 8; k++)
    begin
      if (k == 4)
        continue;
      st = (k < 4) ? 16'(2 * k) : 16'(2 * k - 16);
      wr(wa(8), 32'h0100);
      wr(wa(11), 32'h0140);
      exec({8'hC7, 2'b00, 2'h1, 2'h2, 4'(k), 4'(8 + k), 2'h2}, 1);
      rdck(wa(5), model.rd(16'h0100), "x fetch");
      rdck(wa(8), 16'h0100 + st, "x step");
      rdck(wa(6), model.rd(16'h0140), "y fetch");
      rdck(wa(11), 16'h0140 + st, "y step");
    end
    wr(wa(9), 32'h0100);
    wr(wa(11), 32'h0140);
    wr(wa(12), 32'h0020);
    wr(wa(4), 32'h1111);
    exec({8'hC7, 2'b00, 2'h1, 2'h2, 4'hC, 4'hC, 2'h2}, 1);
    rdck(wa(5), model.rd(16'h0120), "x offset");
    rdck(wa(6), model.rd(16'h0160), "y offset");
    rdck(wa(9), 16'h0100, "w9 kept");
    rdck(wa(11), 16'h0140, "w11 kept");
    wr(wa(5), 32'h1234);
    exec({8'hC7, 2'b00, 2'h1, 2'h0, 4'h4, 4'h4, 2'h2}, 1);
    rdck(wa(5), 16'h1234, "no x fetch");
    rdck(wa(6), model.rd(16'h0160), "no y fetch");
    rdck(wa(4), 16'h1111, "w4 kept");
    // Low halves chosen so only one accumulator rounds up
    wr({20'h0, A_FIRST_ACCUMULATOR_L}, 32'h5555_0000);
    wr({20'h0, A_SECOND_ACCUMULATOR_L}, 32'h1234_8000);
    exec({8'hC7, 2'b00, 2'h0, 2'h0, 4'h4, 4'h4, 2'h0}, 1);
    rdck(wa(13), 16'h1235, "wb reg");
    wr(wa(13), 32'h0200);
    exec({8'hC7, 2'b10, 2'h0, 2'h0, 4'h4, 4'h4, 2'h1}, 1);
    rdck(mba(16'h0200), 16'h5555, "wb mem");
    rdck(wa(13), 16'h0202, "wb ptr");
    wr({20'h0, A_STAT}, 32'h2);
    exec({8'hC7, 2'b00, 2'h0, 2'h0, 4'h4, 4'h4, 2'h3}, 1);
    rdck({20'h0, A_STAT}, 16'h0002, "illegal wb");
    rdck(wa(13), 16'h0202, "w13 kept");
    rdck({20'h0, A_SR}, 16'h00A5, "sr kept");
  endtask : t_psa

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_movd_dir();
    t_movd_ind();
    t_pages();
    t_psa();
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule : tb_move_page_prefetch_exec
